/* rtl/dpp_port_ctrl.sv */
// Purpose: Synchronous host-port control of one dual-port SRAM port
// Assumes: Host pins synchronised here by two flops each
// Notes:   Pipeline latency of the synchronisers adds to every figure except the special-function output and enable paths
`timescale 1ns/1ps
`include "dpp_defines.svh"
module dpp_port_ctrl (
   input  wire logic                   sys_clk_i,
   input  wire logic                   srst_i,
   input  wire logic                   left_port_mux_select_i,
   input  wire logic                   chip_sel_n_i,
   input  wire logic                   write_n_i,
   input  wire logic                   out_en_n_i,
   input  wire logic                   upper_lane_en_n_i,
   input  wire logic                   lower_lane_en_n_i,
   input  wire logic                   addr_strobe_n_i,
   input  wire logic                   burst_count_en_n_i,
   input  wire logic                   burst_repeat_n_i,
   input  wire logic                   sleep_req_i,
   input  wire logic [`DPP_ADDR_W-1:0] addr_i,
   input  wire logic [`DPP_DATA_W-1:0] data_i,
   output logic      [`DPP_DATA_W-1:0] data_o,
   output logic      [1:0]             data_oe_n_o,
   input  wire logic                   special_func_gate_i,
   input  wire logic [`DPP_SF_W-1:0]   special_func_pins_i,
   output logic      [`DPP_SF_W-1:0]   special_func_pins_o,
   output logic      [`DPP_SF_W-1:0]   special_func_pins_oe_n_o,
   input  wire logic [`DPP_SF_W-1:0]   special_func_out_i,
   input  wire logic [`DPP_SF_W-1:0]   special_func_dir_i,
   output logic      [`DPP_SF_W-1:0]   special_func_in_o,
   output logic                        mux_mode_o,
   output logic      [`DPP_ADDR_W-1:0] burst_addr_o
);
   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   dpp_pkg::dpp_ctrl_type  ctl_raw, ctl_s1_q, ctl_s2_q;
   logic [`DPP_ADDR_W-1:0] addr_s1_q, addr_s2_q;
   logic [`DPP_DATA_W-1:0] din_s1_q, din_s2_q;
   logic [`DPP_SF_W-1:0]   sf_s1_q, sf_s2_q;
   logic                   left_port_mux_select_s1_q, left_port_mux_select_s2_q, mux_q;

   assign ctl_raw = '{chip_sel_n: chip_sel_n_i, write_n: write_n_i, out_en_n: out_en_n_i,
                      upper_lane_en_n: upper_lane_en_n_i, lower_lane_en_n: lower_lane_en_n_i,
                      addr_strobe_n: addr_strobe_n_i, burst_count_en_n: burst_count_en_n_i,
                      burst_repeat_n: burst_repeat_n_i, sleep_req: sleep_req_i};

   always_ff @(posedge sys_clk_i) begin
      ctl_s1_q  <= ctl_raw;
      ctl_s2_q  <= ctl_s1_q;
      addr_s1_q <= addr_i;
      addr_s2_q <= addr_s1_q;
      din_s1_q  <= data_i;
      din_s2_q  <= din_s1_q;
      sf_s1_q   <= special_func_pins_i;
      sf_s2_q   <= sf_s1_q;
      left_port_mux_select_s1_q <= left_port_mux_select_i;
      left_port_mux_select_s2_q <= left_port_mux_select_s1_q;
   end

   // Strap follows the synchronised pin every cycle outside reset
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         mux_q <= 1'b0;
      end else begin
         mux_q <= left_port_mux_select_s2_q;
      end
   end
   assign mux_mode_o = mux_q;

   // ---------------------------------------------
   // Address selection and counter
   // ---------------------------------------------
   function automatic logic [1:0] lane_en(input dpp_pkg::dpp_ctrl_type c);
      lane_en = {~c.upper_lane_en_n, ~c.lower_lane_en_n};
   endfunction : lane_en

   logic [`DPP_ADDR_W-1:0] ext_addr, addr_used;

   // Mux port takes the address from the shared data pins
   assign ext_addr = mux_q ? din_s2_q[`DPP_ADDR_W-1:0] : addr_s2_q;

   dpp_addr_ctr u_ctr (
      .sys_clk_i          (sys_clk_i),
      .srst_i             (srst_i),
      .addr_strobe_n_i    (ctl_s2_q.addr_strobe_n),
      .burst_count_en_n_i (ctl_s2_q.burst_count_en_n),
      .burst_repeat_n_i   (ctl_s2_q.burst_repeat_n),
      .ext_addr_i         (ext_addr),
      .addr_used_o        (addr_used),
      .addr_o             (burst_addr_o)
   );

   // ---------------------------------------------
   // Access sequencer
   // ---------------------------------------------
   dpp_pkg::dpp_state_type  st_q, st_d;
   logic [1:0]              lanes_q, lanes_d;
   logic                    rd_q, rd_d;
   logic [1:0]              drive_q, drive_d;
   logic [`DPP_DATA_W-1:0]  dout_q, dout_d;
   dpp_pkg::dpp_mem_req_type req;
   logic [`DPP_DATA_W-1:0]  rdata;
   logic                    sel, go;

   assign sel = ~ctl_s2_q.sleep_req;
   assign go  = sel & ~ctl_s2_q.chip_sel_n;

   always_comb begin
      st_d        = st_q;
      lanes_d     = lanes_q;
      rd_d        = 1'b0;
      req.we      = 1'b0;
      req.lane_we = 2'b00;
      req.addr    = addr_used;
      req.wdata   = din_s2_q;
      if (!sel) begin
         st_d = dpp_pkg::DPP_IDLE;
      end else if (mux_q) begin
         case (st_q)
            dpp_pkg::DPP_WDATA: begin
               // Data phase, and burst continuation while strobe high
               if (ctl_s2_q.addr_strobe_n && !ctl_s2_q.write_n) begin
                  req.we      = 1'b1;
                  req.lane_we = lanes_q;
               end else begin
                  st_d = dpp_pkg::DPP_IDLE;
               end
            end
            dpp_pkg::DPP_RWAIT: begin
               if (ctl_s2_q.addr_strobe_n && ctl_s2_q.write_n) begin
                  rd_d = 1'b1;
               end else begin
                  st_d = dpp_pkg::DPP_IDLE;
               end
            end
            default: begin
               st_d = dpp_pkg::DPP_IDLE;
            end
         endcase
         if (go && !ctl_s2_q.addr_strobe_n) begin
            lanes_d = lane_en(ctl_s2_q);
            st_d    = ctl_s2_q.write_n ? dpp_pkg::DPP_RWAIT : dpp_pkg::DPP_WDATA;
            rd_d    = 1'b0;
            req.we  = 1'b0;
         end
      end else if (go) begin
         lanes_d = lane_en(ctl_s2_q);
         if (!ctl_s2_q.write_n) begin
            req.we      = 1'b1;
            req.lane_we = lane_en(ctl_s2_q);
         end else begin
            rd_d = 1'b1;
         end
      end
   end

   dpp_mem u_mem (
      .sys_clk_i (sys_clk_i),
      .req_i     (req),
      .rdata_o   (rdata)
   );

   // ---------------------------------------------
   // Output drive
   // ---------------------------------------------
   always_comb begin
      dout_d  = dout_q;
      drive_d = 2'b00;
      if (rd_q) begin
         dout_d  = rdata;
         drive_d = lanes_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_q    <= dpp_pkg::DPP_IDLE;
         lanes_q <= 2'b00;
         rd_q    <= 1'b0;
         drive_q <= 2'b00;
         dout_q  <= `DPP_DATA_RST;
      end else begin
         st_q    <= st_d;
         lanes_q <= lanes_d;
         rd_q    <= rd_d;
         drive_q <= drive_d;
         dout_q  <= dout_d;
      end
   end

   // Enables low while driving; sleep and output enable float lanes, chip select is not decoded here
   always_comb begin
      data_oe_n_o = 2'b11;
      if (!ctl_s2_q.sleep_req && !ctl_s2_q.out_en_n) begin
         data_oe_n_o = ~drive_q;
      end
   end
   assign data_o = dout_q;

   // ---------------------------------------------
   // Special-function pins
   // ---------------------------------------------
   always_comb begin
      special_func_pins_o      = special_func_out_i;
      special_func_pins_oe_n_o = {`DPP_SF_W{1'b1}};
      special_func_in_o        = 8'h00;
      if (special_func_gate_i) begin
         special_func_pins_oe_n_o = ~special_func_dir_i;
         special_func_in_o        = sf_s2_q;
      end
   end
endmodule : dpp_port_ctrl

/* common/dpp_defines.svh */
// Purpose: Constants for the dual-port SRAM port controller
// Assumes: 16K x 16 array, one port per instance
// Notes:   Included by the package and the design files
`ifndef DPP_DEFINES_SVH
`define DPP_DEFINES_SVH
`define DPP_DATA_W      16
`define DPP_ADDR_W      14
`define DPP_DEPTH       16384
`define DPP_LANE_W      8
`define DPP_SF_W        8
`define DPP_UPPER_LSB   8
`define DPP_LOWER_LSB   0
`define DPP_RD_LAT      2
`define DPP_ADDR_RST    14'h0000
`define DPP_DATA_RST    16'h0000
`endif

/* common/dpp_pkg.sv */
// Purpose: Types for the dual-port SRAM port controller
// Assumes: dpp_defines.svh on the include path
// Notes:   Types only; constants live in the header
`include "dpp_defines.svh"
package dpp_pkg;
   typedef enum logic [1:0] {DPP_IDLE, DPP_WDATA, DPP_RWAIT} dpp_state_type;

   typedef struct packed {
      logic chip_sel_n;
      logic write_n;
      logic out_en_n;
      logic upper_lane_en_n;
      logic lower_lane_en_n;
      logic addr_strobe_n;
      logic burst_count_en_n;
      logic burst_repeat_n;
      logic sleep_req;
   } dpp_ctrl_type;

   typedef struct packed {
      logic                    we;
      logic [1:0]              lane_we;
      logic [`DPP_ADDR_W-1:0]  addr;
      logic [`DPP_DATA_W-1:0]  wdata;
   } dpp_mem_req_type;
endpackage : dpp_pkg

/* rtl/dpp_addr_ctr.sv */
// Purpose: Burst address counter with load, increment, hold and repeat
// Assumes: Controls already synchronised
// Notes:   Repeat has top priority
`timescale 1ns/1ps
`include "dpp_defines.svh"
module dpp_addr_ctr (
   input  wire logic                   sys_clk_i,
   input  wire logic                   srst_i,
   input  wire logic                   addr_strobe_n_i,
   input  wire logic                   burst_count_en_n_i,
   input  wire logic                   burst_repeat_n_i,
   input  wire logic [`DPP_ADDR_W-1:0] ext_addr_i,
   output logic      [`DPP_ADDR_W-1:0] addr_used_o,
   output logic      [`DPP_ADDR_W-1:0] addr_o
);
   logic [`DPP_ADDR_W-1:0] addr_q, addr_d, last_q, last_d;

   // ---------------------------------------------
   // Next address
   // ---------------------------------------------
   always_comb begin
      addr_d = addr_q;
      last_d = last_q;
      if (!burst_repeat_n_i) begin
         addr_d = last_q;
      end else if (!addr_strobe_n_i) begin
         addr_d = ext_addr_i;
         last_d = ext_addr_i;
      end else if (!burst_count_en_n_i) begin
         addr_d = addr_q + `DPP_ADDR_W'(1);
      end else begin
         addr_d = addr_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         addr_q <= `DPP_ADDR_RST;
         last_q <= `DPP_ADDR_RST;
      end else begin
         addr_q <= addr_d;
         last_q <= last_d;
      end
   end

   assign addr_used_o = addr_d;
   assign addr_o      = addr_q;
endmodule : dpp_addr_ctr

/* rtl/dpp_mem.sv */
// Purpose: 16K x 16 storage with per-lane write
// Assumes: Synchronous read, one cycle
// Notes:   Array declared here
`timescale 1ns/1ps
`include "dpp_defines.svh"
module dpp_mem (
   input  wire logic                    sys_clk_i,
   input  wire dpp_pkg::dpp_mem_req_type req_i,
   output logic      [`DPP_DATA_W-1:0]  rdata_o
);
   logic [`DPP_DATA_W-1:0] mem_q [`DPP_DEPTH];

   // ---------------------------------------------
   // Array access
   // ---------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (req_i.we && req_i.lane_we[1]) begin
         mem_q[req_i.addr][`DPP_UPPER_LSB +: `DPP_LANE_W] <= req_i.wdata[`DPP_UPPER_LSB +: `DPP_LANE_W];
      end
      if (req_i.we && req_i.lane_we[0]) begin
         mem_q[req_i.addr][`DPP_LOWER_LSB +: `DPP_LANE_W] <= req_i.wdata[`DPP_LOWER_LSB +: `DPP_LANE_W];
      end
      rdata_o <= mem_q[req_i.addr];
   end
endmodule : dpp_mem

/* bench/dpp_port_sva.sv */
// Purpose: Port checker
// Assumes: Two-flop input sync
// Notes:   Bound to dpp_port_ctrl
`timescale 1ns/1ps
module dpp_port_sva (
   input wire logic        sys_clk_i,
   input wire logic        srst_i,
   input wire logic        chip_sel_n_i,
   input wire logic        out_en_n_i,
   input wire logic        addr_strobe_n_i,
   input wire logic        burst_count_en_n_i,
   input wire logic        burst_repeat_n_i,
   input wire logic        sleep_req_i,
   input wire logic [13:0] addr_i,
   input wire logic [1:0]  data_oe_n_o,
   input wire logic        special_func_gate_i,
   input wire logic [7:0]  special_func_dir_i,
   input wire logic [7:0]  special_func_pins_oe_n_o,
   input wire logic        mux_mode_o,
   input wire logic [13:0] burst_addr_o
);
   // ------
   // Settle counter
   // ------
   logic [3:0] age_q;
   logic [3:0] age_d;
   logic       ok;
   always_comb age_d = srst_i ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
   always_ff @(posedge sys_clk_i) age_q <= age_d;
   assign ok = (age_q == 4'hF);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   property p_sleep; (ok && sleep_req_i)[*6] |-> data_oe_n_o == 2'h3; endproperty
   a_sleep: assert property (p_sleep) else $error("lanes driven in sleep");
   property p_oe; (ok && out_en_n_i)[*6] |-> data_oe_n_o == 2'h3; endproperty
   a_oe: assert property (p_oe) else $error("lanes driven with output off");
   property p_cs; (ok && chip_sel_n_i && !mux_mode_o)[*8] |-> data_oe_n_o == 2'h3; endproperty
   a_cs: assert property (p_cs) else $error("lanes driven while deselected");
   property p_hold; (ok && addr_strobe_n_i && burst_count_en_n_i && burst_repeat_n_i)[*6] |-> $stable(burst_addr_o);
   endproperty
   a_hold: assert property (p_hold) else $error("address moved on hold");
   property p_inc; (ok && addr_strobe_n_i && !burst_count_en_n_i && burst_repeat_n_i)[*6]
      |-> burst_addr_o == $past(burst_addr_o) + 14'h0001; endproperty
   a_inc: assert property (p_inc) else $error("address not incremented");
   property p_rpt; (ok && !burst_repeat_n_i)[*6] |-> $stable(burst_addr_o); endproperty
   a_rpt: assert property (p_rpt) else $error("address moved on repeat");
   property p_load; (ok && !addr_strobe_n_i && burst_repeat_n_i && !mux_mode_o && $stable(addr_i))[*6]
      |-> burst_addr_o == addr_i; endproperty
   a_load: assert property (p_load) else $error("external address not loaded");
   property p_sf; special_func_pins_oe_n_o == (special_func_gate_i ? ~special_func_dir_i : 8'hFF); endproperty
   a_sf: assert property (p_sf) else $error("special pin enable wrong");
   c_rd: cover property (data_oe_n_o == 2'h0);
   c_inc: cover property ((!burst_count_en_n_i)[*3]);
   c_mux: cover property (mux_mode_o);
endmodule : dpp_port_sva
bind dpp_port_ctrl dpp_port_sva i_sva (.*);

/* bench/dpp_host_model.sv */
// Purpose: Host side of the data and special pins
// Assumes: No pull on either bus
// Notes:   A released lane shows the inverse of its last level
`timescale 1ns/1ps
module dpp_host_model (
   input  wire logic        sys_clk_i,
   input  wire logic [15:0] host_d_i,
   input  wire logic        host_drv_i,
   input  wire logic [15:0] dev_d_i,
   input  wire logic [1:0]  dev_oe_n_i,
   input  wire logic [7:0]  sf_ext_i,
   input  wire logic [7:0]  sf_d_i,
   input  wire logic [7:0]  sf_oe_n_i,
   output logic      [15:0] bus_o,
   output logic      [7:0]  sf_pin_o
);
   logic [15:0] last_q = 16'h0000;
   always_ff @(posedge sys_clk_i) last_q <= bus_o;
   always_comb begin
      bus_o = host_drv_i ? host_d_i : ~last_q;
      if (!dev_oe_n_i[1]) bus_o[15:8] = dev_d_i[15:8];
      if (!dev_oe_n_i[0]) bus_o[7:0] = dev_d_i[7:0];
      sf_pin_o = (sf_d_i & ~sf_oe_n_i) | (sf_ext_i & sf_oe_n_i);
   end
endmodule : dpp_host_model

/* bench/tb_top.sv */
// Purpose: Port controller bench
// Assumes: Control word order as dpp_ctrl_type
// Notes:   Separate-pin tests first, then mux
`timescale 1ns/1ps
module tb_top;
   logic                  sys_clk_i = 1'b0;
   logic                  srst_i    = 1'b1;
   logic                  left_port_mux_select      = 1'b0;
   dpp_pkg::dpp_ctrl_type c         = 9'h186;
   logic [13:0]           addr      = 14'h0000;
   logic [15:0]           hd        = 16'h0000;
   logic                  hdrv      = 1'b0;
   logic                  sfg       = 1'b0;
   logic [7:0]            sfo       = 8'h00;
   logic [7:0]            sfd       = 8'h00;
   logic [7:0]            sfx       = 8'h00;
   logic [15:0]           bus, dout;
   logic [1:0]            oe_n;
   logic [7:0]            sfp, sfpo, sfoe, sfin;
   logic [13:0]           baddr;
   logic                  mux;
   int                    bad_count = 0;
   int                    tests_run = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   dpp_port_ctrl i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .left_port_mux_select_i(left_port_mux_select),
      .chip_sel_n_i(c.chip_sel_n), .write_n_i(c.write_n), .out_en_n_i(c.out_en_n),
      .upper_lane_en_n_i(c.upper_lane_en_n), .lower_lane_en_n_i(c.lower_lane_en_n),
      .addr_strobe_n_i(c.addr_strobe_n), .burst_count_en_n_i(c.burst_count_en_n),
      .burst_repeat_n_i(c.burst_repeat_n), .sleep_req_i(c.sleep_req), .addr_i(addr), .data_i(bus),
      .data_o(dout), .data_oe_n_o(oe_n), .special_func_gate_i(sfg), .special_func_pins_i(sfp),
      .special_func_pins_o(sfpo), .special_func_pins_oe_n_o(sfoe), .special_func_out_i(sfo),
      .special_func_dir_i(sfd), .special_func_in_o(sfin), .mux_mode_o(mux), .burst_addr_o(baddr));
   dpp_host_model i_host (.sys_clk_i(sys_clk_i), .host_d_i(hd), .host_drv_i(hdrv), .dev_d_i(dout),
      .dev_oe_n_i(oe_n), .sf_ext_i(sfx), .sf_d_i(sfpo), .sf_oe_n_i(sfoe), .bus_o(bus), .sf_pin_o(sfp));
   // ------
   // Shared tasks
   // ------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic cyc(input logic [8:0] k, input logic [13:0] a, input logic [15:0] d, input logic dr);
      c <= k;
      addr <= a;
      hd <= d;
      hdrv <= dr;
      @(posedge sys_clk_i);
   endtask : cyc
   task automatic idle(input logic [8:0] k);
      cyc(k, addr, 16'h0000, 1'b0);
      repeat (8) @(posedge sys_clk_i);
   endtask : idle
   task automatic rst(input logic m, input logic [8:0] k);
      srst_i <= 1'b1;
      left_port_mux_select <= m;
      c <= k;
      repeat (4) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
   endtask : rst
   task automatic rd(input logic [1:0] eo, input logic [15:0] ex);
      int n;
      n = 0;
      @(negedge sys_clk_i);
      while (oe_n === 2'h3 && n < 12) begin
         @(negedge sys_clk_i);
         n++;
      end
      chk(16'(oe_n), 16'(eo));
      chk({oe_n[1] ? 8'h00 : bus[15:8], oe_n[0] ? 8'h00 : bus[7:0]}, ex);
      @(posedge sys_clk_i);
   endtask : rd
   // ------
   // Scenarios
   // ------
   task automatic t_sep;
      logic [8:0]  rk [6] = '{9'h086, 9'h096, 9'h0A6, 9'h0B6, 9'h0C6, 9'h087};
      logic [8:0]  rw [6] = '{9'h186, 9'h186, 9'h186, 9'h186, 9'h1C6, 9'h187};
      logic [1:0]  ro [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
      logic [15:0] rx [6] = '{16'h7EC3, 16'h7E00, 16'h00C3, 16'h0000, 16'h0000, 16'h0000};
      cyc(9'h046, 14'h0123, 16'hA5C3, 1'b1);
      cyc(9'h056, 14'h0123, 16'h7E11, 1'b1);
      cyc(9'h146, 14'h0123, 16'hFFFF, 1'b1);
      for (int i = 0; i < 6; i++) begin
         cyc(rk[i], 14'h0123, 16'h0000, 1'b0);
         cyc(rw[i], 14'h0123, 16'h0000, 1'b0);
         rd(ro[i], rx[i]);
         idle(9'h186);
      end
      chk(16'(baddr), 16'h0123);
      $display("t_sep done");
   endtask : t_sep
   task automatic t_sf;
      sfg <= 1'b1;
      sfd <= 8'h0F;
      sfo <= 8'h5A;
      sfx <= 8'h3C;
      repeat (4) @(negedge sys_clk_i);
      chk({sfpo, sfoe}, 16'h5AF0);
      chk(16'(sfin), 16'h003A);
      @(posedge sys_clk_i);
      sfg <= 1'b0;
      repeat (4) @(negedge sys_clk_i);
      chk({sfin, sfoe}, 16'h00FF);
      @(posedge sys_clk_i);
      $display("t_sf done");
   endtask : t_sf
   task automatic t_mux;
      chk(16'(mux), 16'h0001);
      cyc(9'h046, 14'h0000, 16'h0200, 1'b1);
      cyc(9'h04E, 14'h0000, 16'h1111, 1'b1);
      cyc(9'h04A, 14'h0000, 16'h2222, 1'b1);
      cyc(9'h04A, 14'h0000, 16'h3333, 1'b1);
      idle(9'h1CE);
      chk(16'(baddr), 16'h0202);
      idle(9'h1CA);
      idle(9'h1CC);
      chk(16'(baddr), 16'h0200);
      idle(9'h1CE);
      for (int i = 0; i < 3; i++) begin
         cyc(9'h0C6, 14'h0000, 16'h0200 + 16'(i), 1'b1);
         cyc(9'h08E, 14'h0000, 16'h0000, 1'b0);
         rd(2'h0, 16'h1111 * 16'(i + 1));
         idle(9'h1C6);
      end
      $display("t_mux done");
   endtask : t_mux
   initial begin
      rst(1'b0, 9'h186);
      t_sep();
      t_sf();
      rst(1'b1, 9'h1CE);
      t_mux();
      finish_test();
   end
   initial begin
      repeat (3000) @(posedge sys_clk_i);
      bad_count++;
      finish_test();
   end
endmodule : tb_top
